// ### bench/ioc_pad_model.sv
`timescale 1ns/1ps
module ioc_pad_model (
	input wire logic core_clk,
	input wire logic [1:0] padOutData,
	input wire logic [1:0] padOeCtrl,
	input wire logic [1:0] extData,
	input wire logic extDrive,
	output logic [1:0] padIn
);
	// ------------------------------------------------------------
	// pad wire
	// ------------------------------------------------------------
	logic [1:0] noise_r = 2'h1;
	// floating pad must not look like held data
	always_ff @(posedge core_clk) begin
		noise_r <= ~noise_r;
	end
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			padIn[i] = padOeCtrl[i] ? padOutData[i] :
				(extDrive ? extData[i] : noise_r[i]);
		end
	end
endmodule

// ### bench/ioc_pair_properties.sv
`timescale 1ns/1ps
module ioc_pair_chk (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic clkEn,
	input wire logic localSetReset,
	input wire logic globalSetResetN,
	input wire logic rawStrobeIn,
	input wire logic [1:0] padIn,
	input wire logic [1:0] padOutData,
	input wire logic [1:0] inBypass,
	input wire logic [1:0] inPosA,
	input wire logic [1:0] captureValid,
	input wire logic preambleDetect
);
	// ------------------------------------------------------------
	// bus and pin relations
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_ans;
		ack_o ##1 !ack_o;
	endsequence
	property p_ack_time;
		s_req |=> s_ans;
	endproperty
	a_ack_time: assert property (p_ack_time) else $error("ack timing");
	property p_ack_src;
		ack_o |-> $past(cyc_i && stb_i);
	endproperty
	a_ack_src: assert property (p_ack_src) else $error("ack unasked");
	property p_wr_zero;
		ack_o && $past(we_i) |-> dat_o == 32'h0;
	endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("write data out");
	property p_rst;
		$fell(reset) |-> !ack_o && inPosA == 2'h0 && captureValid == 2'h0
			&& preambleDetect;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values");
	// held enable must outlast the two sync flops
	property p_hold_in;
		(!clkEn && !localSetReset && globalSetResetN)[*4] |=> $stable(inPosA);
	endproperty
	a_hold_in: assert property (p_hold_in) else $error("input moved");
	property p_hold_out;
		(!clkEn && !localSetReset && globalSetResetN)[*4]
			|=> $stable(padOutData);
	endproperty
	a_hold_out: assert property (p_hold_out) else $error("out moved");
	property p_bypass;
		$stable(padIn)[*8] |-> inBypass[0] == padIn[0];
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass");
	property p_preamble;
		$stable(rawStrobeIn)[*6] |-> preambleDetect == rawStrobeIn;
	endproperty
	a_preamble: assert property (p_preamble) else $error("preamble");
endmodule

bind ioc_pair ioc_pair_chk chk_i (.core_clk, .reset, .cyc_i, .stb_i, .we_i,
	.dat_o, .ack_o, .clkEn, .localSetReset, .globalSetResetN, .rawStrobeIn,
	.padIn, .padOutData, .inBypass, .inPosA, .captureValid, .preambleDetect);

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import ioc_pkg::*;
	// ------------------------------------------------------------
	// stimulus nets
	// ------------------------------------------------------------
	logic core_clk = 1'b0, reset = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
	logic we_i = 1'b0, sysClk = 1'b0, edgeClkA = 1'b0, edgeClkB = 1'b0;
	logic shiftedReadStrobe = 1'b0, writeClk0 = 1'b0, writeClk1 = 1'b0;
	logic strobeWriteClk = 1'b0, rawStrobeIn = 1'b1, clkEn = 1'b1;
	logic localSetReset = 1'b0, globalSetResetN = 1'b1;
	logic syncClkPolarity = 1'b0, gearLatchEnable = 1'b0, extDrive = 1'b1;
	logic [ADDR_W-1:0] adr_i = 4'h0;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic [DLY_W-1:0] inDelayCode = 4'h0;
	logic [SHIFT_W-1:0] writeClkShift = 8'hA5;
	logic [DLL_W-1:0] dllDelayCode = 7'h33;
	logic [1:0] padIn, padOutData, padOeCtrl, inBypass, inClockPath;
	logic [1:0] inPosA, inNegA, inPosB, inNegB, captureValid;
	logic [1:0] outPosA = 2'h0, outNegA = 2'h0, outPosB = 2'h0;
	logic [1:0] outNegB = 2'h0, tristateIn = 2'h3, extData = 2'h0;
	logic ack_o, preambleDetect;
	int err_total = 0, samples_checked = 0, hpN = 0;

	always #5 core_clk = ~core_clk;
	ioc_pair dut (.core_clk, .reset, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .sysClk, .edgeClkA, .edgeClkB,
		.shiftedReadStrobe, .writeClk0, .writeClk1, .strobeWriteClk,
		.rawStrobeIn, .clkEn, .localSetReset, .globalSetResetN,
		.syncClkPolarity, .gearLatchEnable, .inDelayCode, .writeClkShift,
		.dllDelayCode, .padIn, .padOutData, .padOeCtrl, .inBypass,
		.inClockPath, .inPosA, .inNegA, .inPosB, .inNegB, .outPosA,
		.outNegA, .outPosB, .outNegB, .tristateIn, .captureValid,
		.preambleDetect);
	ioc_pad_model pads (.core_clk, .padOutData, .padOeCtrl, .extData,
		.extDrive, .padIn);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wb(logic w, logic [3:0] a, logic [3:0] s, logic [31:0] d);
		@(posedge core_clk);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= d;
		do begin
			@(posedge core_clk);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge core_clk);
	endtask
	// half periods of 6,6,6,7 cycles give a 125 ns link clock
	task automatic hp();
		hpN++;
		repeat ((hpN % 4 == 0) ? 7 : 6) @(posedge core_clk);
	endtask
	task automatic lk(int c, logic v);
		@(posedge core_clk);
		case (c)
			0: sysClk <= v;
			1: edgeClkA <= v;
			2: edgeClkB <= v;
			3: shiftedReadStrobe <= v;
			4: writeClk0 <= v;
			default: writeClk1 <= v;
		endcase
		hp();
	endtask
	task automatic sys_cycle();
		hp();
		lk(0, 1'b1);
		lk(0, 1'b0);
		@(negedge core_clk);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		wb(1'b0, ADR_CTRL, 4'hF, 32'h0);
		chk("ctrl reset", rd, CTRL_RST);
		wb(1'b0, ADR_SHIFT, 4'hF, 32'h0);
		chk("shift reset", rd, SHIFT_RST);
		wb(1'b0, ADR_DLY, 4'hF, 32'h0);
		chk("delay reset", rd, DLY_RST);
		wb(1'b1, ADR_SHIFT, 4'h1, 32'h5A);
		chk("write data", rd, 32'h0);
		wb(1'b1, ADR_SHIFT, 4'h2, 32'hFF);
		wb(1'b0, ADR_SHIFT, 4'hF, 32'h0);
		chk("static shift", rd, 32'h5A);
		wb(1'b1, ADR_CTRL, 4'h2, 32'h3FF);
		wb(1'b0, ADR_CTRL, 4'hF, 32'h0);
		chk("ctrl bytes", rd, 32'h300);
		wb(1'b1, 4'h2, 4'hF, 32'hFFFF);
		wb(1'b0, 4'h2, 4'hF, 32'h0);
		chk("unmapped", rd, 32'h0);
		wb(1'b1, ADR_STAT, 4'hF, 32'hFFFFFFFF);
		wb(1'b0, ADR_STAT, 4'hF, 32'h0);
		chk("dynamic shift", rd[15:8], 8'hA5);
		chk("dll code", rd[22:16], 7'h33);
		wb(1'b1, ADR_CTRL, 4'hF, 32'h20);
		wb(1'b0, ADR_STAT, 4'hF, 32'h0);
		chk("chosen shift", rd[15:8], 8'h5A);
		wb(1'b1, ADR_CTRL, 4'hF, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_sdr_in();
		@(posedge core_clk);
		extData <= 2'h3;
		sys_cycle();
		chk("sdr capture", inPosA, 2'h3);
		@(posedge core_clk);
		clkEn <= 1'b0;
		extData <= 2'h0;
		sys_cycle();
		chk("enable low", inPosA, 2'h3);
		@(posedge core_clk);
		clkEn <= 1'b1;
		sys_cycle();
		chk("enable high", inPosA, 2'h0);
		$display("test sdr in done");
	endtask
	task automatic t_ddr(logic [31:0] ctrl, int c, logic pol,
		logic [1:0] d1, logic [1:0] d2);
		wb(1'b1, ADR_CTRL, 4'hF, ctrl);
		@(posedge core_clk);
		syncClkPolarity <= pol;
		extData <= d1;
		hp();
		lk(c, 1'b1);
		extData <= d2;
		hp();
		lk(c, 1'b0);
		sys_cycle();
		chk("valid set", captureValid, 2'h3);
		sys_cycle();
		chk("valid clear", captureValid, 2'h0);
		chk("ddr rise", inPosA, d1);
		chk("ddr fall", inNegA, d2);
		$display("test ddr done");
	endtask
	task automatic t_out();
		wb(1'b1, ADR_CTRL, 4'hF, 32'h0);
		@(posedge core_clk);
		tristateIn <= 2'h0;
		outPosA <= 2'h1;
		outNegA <= 2'h2;
		outPosB <= 2'h3;
		outNegB <= 2'h1;
		sys_cycle();
		chk("drive on", padOeCtrl, 2'h3);
		chk("sdr out", padOutData, 2'h1);
		chk("no clock path", inClockPath, 2'h0);
		wb(1'b1, ADR_CTRL, 4'hF, 32'h18);
		@(posedge core_clk);
		outPosA <= 2'h3;
		sys_cycle();
		chk("pair out", padOutData, 2'h1);
		chk("clock path", inClockPath, 2'h1);
		chk("bypass", inBypass, 2'h1);
		@(posedge core_clk);
		tristateIn <= 2'h3;
		sys_cycle();
		chk("drive off", padOeCtrl, 2'h0);
		$display("test out done");
	endtask
	task automatic t_dout();
		wb(1'b1, ADR_CTRL, 4'hF, 32'h81);
		@(posedge core_clk);
		tristateIn <= 2'h0;
		outPosA <= 2'h1;
		outNegA <= 2'h2;
		outPosB <= 2'h3;
		outNegB <= 2'h0;
		sys_cycle();
		// shift bit 7 is set, so a pin rise is a falling write clock
		lk(4, 1'b1);
		@(negedge core_clk);
		chk("gear posb", padOutData, 2'h3);
		lk(5, 1'b1);
		@(negedge core_clk);
		chk("gear negb", padOutData, 2'h0);
		lk(4, 1'b0);
		@(negedge core_clk);
		chk("gear posa", padOutData, 2'h1);
		lk(5, 1'b0);
		@(negedge core_clk);
		chk("gear nega", padOutData, 2'h2);
		chk("gear drive", padOeCtrl, 2'h3);
		$display("test ddr out done");
	endtask
	task automatic t_sr();
		wb(1'b1, ADR_CTRL, 4'hF, 32'h40);
		@(posedge core_clk);
		globalSetResetN <= 1'b0;
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		chk("global set", inPosA, 2'h3);
		chk("global set b", inNegB, 2'h3);
		@(posedge core_clk);
		globalSetResetN <= 1'b1;
		wb(1'b1, ADR_CTRL, 4'hF, 32'h0);
		@(posedge core_clk);
		localSetReset <= 1'b1;
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		chk("local clear", inPosA, 2'h0);
		chk("local clear b", inPosB, 2'h0);
		@(posedge core_clk);
		localSetReset <= 1'b0;
		$display("test set reset done");
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		t_regs();
		t_sdr_in();
		t_ddr(32'h1, 1, 1'b0, 2'h3, 2'h0);
		t_ddr(32'h3, 2, 1'b1, 2'h0, 2'h3);
		// memory capture waits for a low preamble
		@(posedge core_clk);
		rawStrobeIn <= 1'b0;
		hp();
		t_ddr(32'h5, 3, 1'b0, 2'h3, 2'h0);
		@(posedge core_clk);
		rawStrobeIn <= 1'b1;
		t_out();
		t_dout();
		t_sr();
		final_report();
	end
endmodule

// ### rtl/ioc_pair.sv
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - pair holds two cells, each driving pad data and enable, reading pad
// - two cells joinable as differential pair, cell 1 complements cell 0
// - bypass input skips registers, separate from clock path output
// - captured input delivered on four core ports per cell
// - core output on four ports; at strobe pad negB drives tristate
// - clock enable gates input and output block flops
// - register blocks clocked by system clock
// - one mux picks edge clock a or b for whole cell
// - memory mode captures DDR input with shifted read strobe
// - polarity input picks system clock edge for DDR domain transfer; SDR transfer stays on the rising edge
// - gear latch enable loads gearing flop selectively
// - 4-bit dynamic input delay code selects input delay
// - output gearing uses two write clocks 90 degrees apart
// - strobe write clock drives only strobe pad output and tristate
// - shift bits 6:0 move write clocks in 25ps steps, 128 steps; here all 128 fall below one core period and stay on tap zero
// - shift bit 7 inverts the shifted write clock
// - static 8-bit shift setting chosen by a config bit
// - cell receives 7-bit delay code from delay-locked loop
// - capture valid flag tells core input data is captured
// - preamble detect from raw strobe, high when tristated, to logic and core
// - clock input cell routes pad onto clock path output
// - SDR tristate control taken from core tristate input
// - DDR input sampled on rising and falling capture edges
// - SDR input registered on system clock
module ioc_pair #(
	parameter int DLY_TAPS = ioc_pkg::DLY_TAPS,
	parameter int WCLK_TAPS = ioc_pkg::WCLK_TAPS,
	parameter int STROBE_IDX = 1
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ioc_pkg::ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic sysClk,
	input wire logic edgeClkA,
	input wire logic edgeClkB,
	input wire logic shiftedReadStrobe,
	input wire logic writeClk0,
	input wire logic writeClk1,
	input wire logic strobeWriteClk,
	input wire logic rawStrobeIn,
	input wire logic clkEn,
	input wire logic localSetReset,
	input wire logic globalSetResetN,
	input wire logic syncClkPolarity,
	input wire logic gearLatchEnable,
	input wire logic [ioc_pkg::DLY_W-1:0] inDelayCode,
	input wire logic [ioc_pkg::SHIFT_W-1:0] writeClkShift,
	input wire logic [ioc_pkg::DLL_W-1:0] dllDelayCode,
	input wire logic [1:0] padIn,
	output logic [1:0] padOutData,
	output logic [1:0] padOeCtrl,
	output logic [1:0] inBypass,
	output logic [1:0] inClockPath,
	output logic [1:0] inPosA,
	output logic [1:0] inNegA,
	output logic [1:0] inPosB,
	output logic [1:0] inNegB,
	input wire logic [1:0] outPosA,
	input wire logic [1:0] outNegA,
	input wire logic [1:0] outPosB,
	input wire logic [1:0] outNegB,
	input wire logic [1:0] tristateIn,
	output logic [1:0] captureValid,
	output logic preambleDetect
);
	import ioc_pkg::*;

	localparam int SYNC_W = 13 + DLY_W + SHIFT_W + DLL_W + 12;
	localparam int WT_W = $clog2(WCLK_TAPS);
	localparam int DT_W = $clog2(DLY_TAPS);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	// every input but reset and the Wishbone port crosses; globalSetResetN and rawStrobeIn inverted so reset reads idle
	logic [SYNC_W-1:0] syncQ;
	logic [1:0] sTs, sONb, sOPb, sONa, sOPa, sPad;
	logic [DLL_W-1:0] sDll;
	logic [SHIFT_W-1:0] sWshift;
	logic [DLY_W-1:0] sDly;
	logic sGsr, sLsr, sCe, sPol, sLat, sRawN;
	logic sSwc, sWc1, sWc0, sDqsr, sEb, sEa, sSys;

	ioc_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk(core_clk),
		.reset(reset),
		.d({tristateIn, outNegB, outPosB, outNegA, outPosA, padIn,
			dllDelayCode, writeClkShift, inDelayCode, ~globalSetResetN,
			localSetReset, clkEn, syncClkPolarity, gearLatchEnable,
			~rawStrobeIn, strobeWriteClk, writeClk1, writeClk0,
			shiftedReadStrobe, edgeClkB, edgeClkA, sysClk}),
		.q(syncQ)
	);

	assign {sTs, sONb, sOPb, sONa, sOPa, sPad, sDll, sWshift, sDly, sGsr,
		sLsr, sCe, sPol, sLat, sRawN, sSwc, sWc1, sWc0, sDqsr, sEb, sEa,
		sSys} = syncQ;

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_r;
	logic [SHIFT_W-1:0] shift_r;
	logic [DLY_W-1:0] dly_r;
	logic ack_r;
	logic [31:0] rdat_r;
	logic [31:0] rdat_nxt;
	logic wbHit, wbWr;
	logic [1:0] valid;
	logic prmb_r;
	logic [SHIFT_W-1:0] effShift;

	assign wbHit = cyc_i & stb_i & ~ack_r;
	assign wbWr = cyc_i & stb_i & we_i & ack_r; // lands on the ack edge
	assign ack_o = ack_r;
	assign dat_o = rdat_r;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= wbHit;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl_r <= CTRL_RST;
			shift_r <= SHIFT_RST;
			dly_r <= DLY_RST;
		end else if (wbWr) begin
			if (adr_i == ADR_CTRL && sel_i[0]) begin
				ctrl_r[CTRL_LO_W-1:0] <= dat_i[CTRL_LO_W-1:0];
			end
			if (adr_i == ADR_CTRL && sel_i[1]) begin
				ctrl_r[CTRL_W-1:CTRL_LO_W] <= dat_i[CTRL_W-1:CTRL_LO_W];
			end
			if (adr_i == ADR_SHIFT && sel_i[0]) begin
				shift_r <= dat_i[SHIFT_W-1:0];
			end
			if (adr_i == ADR_DLY && sel_i[0]) begin
				dly_r <= dat_i[DLY_W-1:0];
			end
		end
	end

	always_comb begin
		case (adr_i)
			ADR_CTRL: rdat_nxt = 32'(ctrl_r);
			ADR_SHIFT: rdat_nxt = 32'(shift_r);
			ADR_STAT: rdat_nxt = {9'h000, sDll, effShift, 5'h00, prmb_r,
				valid};
			ADR_DLY: rdat_nxt = 32'(dly_r);
			default: rdat_nxt = 32'h00000000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdat_r <= 32'h00000000;
		end else if (wbHit) begin
			rdat_r <= we_i ? 32'h00000000 : rdat_nxt;
		end
	end

	// ------------------------------------------------------------
	// clock edge detection
	// ------------------------------------------------------------
	logic sysPrev_r, capPrev_r, capClk;
	logic sysRise, sysFall, capRise, capFall, xferTick;
	logic cellClr, setVal;

	// one mux for the whole pair, strobe replaces it in memory mode
	assign capClk = ctrl_r[C_MEM] ? sDqsr :
		(ctrl_r[C_EDGE] ? sEb : sEa);
	assign sysRise = sSys & ~sysPrev_r;
	assign sysFall = ~sSys & sysPrev_r;
	assign capRise = capClk & ~capPrev_r;
	assign capFall = ~capClk & capPrev_r;
	assign xferTick = sPol ? sysFall : sysRise;
	assign cellClr = sLsr | sGsr;
	assign setVal = ctrl_r[C_SETVAL];

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sysPrev_r <= 1'b0;
			capPrev_r <= 1'b0;
		end else begin
			sysPrev_r <= sSys;
			capPrev_r <= capClk;
		end
	end

	// ------------------------------------------------------------
	// preamble detect
	// ------------------------------------------------------------
	// pad bias holds an idle strobe high; a low level opens a read
	logic armed_r, capArm;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			prmb_r <= 1'b1;
			armed_r <= 1'b0;
		end else begin
			prmb_r <= ~sRawN;
			if (!ctrl_r[C_MEM]) begin
				armed_r <= 1'b0;
			end else if (!prmb_r) begin
				armed_r <= 1'b1;
			end
		end
	end

	assign capArm = ~ctrl_r[C_MEM] | armed_r;
	assign preambleDetect = prmb_r;

	// ------------------------------------------------------------
	// write clock shift
	// ------------------------------------------------------------
	// steps below one core period collapse onto tap zero
	logic [WT_W-1:0] wTap;
	logic [WCLK_TAPS-1:0] wc0Line_r, wc1Line_r, swcLine_r;
	logic wInv, w0, w1, ws, w0Prev_r, w1Prev_r, wsPrev_r;
	logic w0Rise, w0Fall, w1Rise, w1Fall, wsRise, wsFall;
	int shiftCyc;

	assign effShift = ctrl_r[C_STSEL] ? shift_r : sWshift;
	assign wInv = effShift[SHIFT_INV];

	always_comb begin
		shiftCyc = int'(effShift[SHIFT_INV-1:0]) * SHIFT_STEP_PS /
			CLK_PERIOD_PS;
		if (shiftCyc > WCLK_TAPS - 1) begin
			wTap = WT_W'(WCLK_TAPS - 1);
		end else begin
			wTap = WT_W'(shiftCyc);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wc0Line_r <= '0;
			wc1Line_r <= '0;
			swcLine_r <= '0;
		end else begin
			wc0Line_r <= {wc0Line_r[WCLK_TAPS-2:0], sWc0 ^ wInv};
			wc1Line_r <= {wc1Line_r[WCLK_TAPS-2:0], sWc1 ^ wInv};
			swcLine_r <= {swcLine_r[WCLK_TAPS-2:0], sSwc ^ wInv};
		end
	end

	assign w0 = wc0Line_r[wTap];
	assign w1 = wc1Line_r[wTap];
	assign ws = swcLine_r[wTap];

	always_ff @(posedge core_clk) begin
		if (reset) begin
			w0Prev_r <= 1'b0;
			w1Prev_r <= 1'b0;
			wsPrev_r <= 1'b0;
		end else begin
			w0Prev_r <= w0;
			w1Prev_r <= w1;
			wsPrev_r <= ws;
		end
	end

	assign w0Rise = w0 & ~w0Prev_r;
	assign w0Fall = ~w0 & w0Prev_r;
	assign w1Rise = w1 & ~w1Prev_r;
	assign w1Fall = ~w1 & w1Prev_r;
	assign wsRise = ws & ~wsPrev_r;
	assign wsFall = ~ws & wsPrev_r;

	// ------------------------------------------------------------
	// io cells
	// ------------------------------------------------------------
	logic [1:0] padQ, oeQ;

	for (genvar i = 0; i < 2; i++) begin : g_cell
		logic [DLY_TAPS-1:0] dlyLine_r;
		logic [DT_W-1:0] dTap;
		logic dIn, isStrobe;
		logic byp_r, ck_r, capPos_r, capNeg_r, gearPos_r, gearNeg_r;
		logic xPa_r, xNa_r, xPb_r, xNb_r, newCap_r, valid_r;
		logic oPa_r, oNa_r, oPb_r, oNb_r, ts_r, pad_r, oe_r;
		logic wLoad;
		ioc_phase_t phase;

		assign dTap = DT_W'(ctrl_r[C_DYNDLY] ? sDly : dly_r);
		assign dIn = dlyLine_r[dTap];
		assign isStrobe = (i == STROBE_IDX) && ctrl_r[C_STRB];

		always_ff @(posedge core_clk) begin
			if (reset) begin
				dlyLine_r <= '0;
				byp_r <= 1'b0;
				ck_r <= 1'b0;
			end else begin
				dlyLine_r <= {dlyLine_r[DLY_TAPS-2:0], sPad[i]};
				byp_r <= sPad[i];
				ck_r <= ctrl_r[C_CLKIN] & sPad[i];
			end
		end

		// capture stage on the selected edge clock
		always_ff @(posedge core_clk) begin
			if (reset) begin
				capPos_r <= 1'b0;
				capNeg_r <= 1'b0;
				gearPos_r <= 1'b0;
				gearNeg_r <= 1'b0;
			end else if (cellClr) begin
				capPos_r <= setVal;
				capNeg_r <= setVal;
				gearPos_r <= setVal;
				gearNeg_r <= setVal;
			end else if (ctrl_r[C_DDR] && sCe && capArm) begin
				if (capRise) begin
					capPos_r <= dIn;
				end
				if (capFall) begin
					capNeg_r <= dIn;
				end
				if (ctrl_r[C_GEAR] && capRise && sLat) begin
					gearPos_r <= capPos_r;
					gearNeg_r <= capNeg_r;
				end
			end
		end

		// set wins over the clear of a transfer
		always_ff @(posedge core_clk) begin
			if (reset || cellClr) begin
				newCap_r <= 1'b0;
			end else if (ctrl_r[C_DDR] && sCe && capArm && capFall) begin
				newCap_r <= 1'b1;
			end else if (xferTick && sCe) begin
				newCap_r <= 1'b0;
			end
		end

		// transfer into the system clock domain
		always_ff @(posedge core_clk) begin
			if (reset) begin
				xPa_r <= 1'b0;
				xNa_r <= 1'b0;
				xPb_r <= 1'b0;
				xNb_r <= 1'b0;
				valid_r <= 1'b0;
			end else if (cellClr) begin
				xPa_r <= setVal;
				xNa_r <= setVal;
				xPb_r <= setVal;
				xNb_r <= setVal;
				valid_r <= 1'b0;
			end else if (!ctrl_r[C_DDR] && sysRise && sCe) begin
				xPa_r <= dIn;
				valid_r <= 1'b1;
			end else if (ctrl_r[C_DDR] && xferTick && sCe) begin
				xPa_r <= capPos_r;
				xNa_r <= capNeg_r;
				xPb_r <= ctrl_r[C_GEAR] & gearPos_r;
				xNb_r <= ctrl_r[C_GEAR] & gearNeg_r;
				valid_r <= newCap_r;
			end
		end

		// output and tristate registers on the system clock
		always_ff @(posedge core_clk) begin
			if (reset) begin
				oPa_r <= 1'b0;
				oNa_r <= 1'b0;
				oPb_r <= 1'b0;
				oNb_r <= 1'b0;
				ts_r <= 1'b1;
			end else if (cellClr) begin
				oPa_r <= setVal;
				oNa_r <= setVal;
				oPb_r <= setVal;
				oNb_r <= setVal;
				ts_r <= 1'b1;
			end else if (sysRise && sCe) begin
				oPa_r <= sOPa[i];
				oNa_r <= sONa[i];
				oPb_r <= sOPb[i];
				oNb_r <= sONb[i];
				ts_r <= isStrobe ? sONb[i] : sTs[i];
			end
		end

		// gearing phase from the shifted write clocks
		always_comb begin
			wLoad = 1'b0;
			phase = PH_POSA;
			if (isStrobe) begin
				wLoad = wsRise | wsFall;
				phase = wsRise ? PH_POSA : PH_NEGA;
			end else if (ctrl_r[C_GEAR]) begin
				wLoad = w0Rise | w1Rise | w0Fall | w1Fall;
				if (w0Rise) begin
					phase = PH_POSA;
				end else if (w1Rise) begin
					phase = PH_NEGA;
				end else if (w0Fall) begin
					phase = PH_POSB;
				end else begin
					phase = PH_NEGB;
				end
			end else begin
				wLoad = w0Rise | w0Fall;
				phase = w0Rise ? PH_POSA : PH_NEGA;
			end
		end

		always_ff @(posedge core_clk) begin
			if (reset) begin
				pad_r <= 1'b0;
				oe_r <= 1'b0;
			end else if (cellClr) begin
				pad_r <= setVal;
				oe_r <= 1'b0;
			end else if (!ctrl_r[C_DDR]) begin
				if (sysRise && sCe) begin
					pad_r <= sOPa[i];
					oe_r <= ~sTs[i];
				end
			end else if (wLoad && sCe) begin
				oe_r <= ~ts_r;
				case (phase)
					PH_POSA: pad_r <= oPa_r;
					PH_NEGA: pad_r <= oNa_r;
					PH_POSB: pad_r <= oPb_r;
					PH_NEGB: pad_r <= oNb_r;
					default: pad_r <= oPa_r;
				endcase
			end
		end

		assign padQ[i] = pad_r;
		assign oeQ[i] = oe_r;
		assign inBypass[i] = byp_r;
		assign inClockPath[i] = ck_r;
		assign inPosA[i] = xPa_r;
		assign inNegA[i] = xNa_r;
		assign inPosB[i] = xPb_r;
		assign inNegB[i] = xNb_r;
		assign valid[i] = valid_r;
	end

	assign captureValid = valid;

	// ------------------------------------------------------------
	// pad drivers and differential pairing
	// ------------------------------------------------------------
	logic [1:0] padOut_r, padOe_r;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			padOut_r <= 2'h0;
			padOe_r <= 2'h0;
		end else begin
			padOut_r[0] <= padQ[0];
			padOe_r[0] <= oeQ[0];
			padOut_r[1] <= ctrl_r[C_DIFF] ? ~padQ[0] : padQ[1];
			padOe_r[1] <= ctrl_r[C_DIFF] ? oeQ[0] : oeQ[1];
		end
	end

	assign padOutData = padOut_r;
	assign padOeCtrl = padOe_r;
endmodule

// ### rtl/ioc_pkg.sv
package ioc_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] ADR_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADR_SHIFT = 4'h4;
	localparam logic [ADDR_W-1:0] ADR_STAT = 4'h8;
	localparam logic [ADDR_W-1:0] ADR_DLY = 4'hC;

	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	localparam int CTRL_W = 10;
	localparam int C_DDR = 0;
	localparam int C_EDGE = 1;
	localparam int C_MEM = 2;
	localparam int C_DIFF = 3;
	localparam int C_CLKIN = 4;
	localparam int C_STSEL = 5;
	localparam int C_SETVAL = 6;
	localparam int C_GEAR = 7;
	localparam int C_DYNDLY = 8;
	localparam int C_STRB = 9;
	localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
	localparam int CTRL_LO_W = 8;

	// ------------------------------------------------------------
	// write clock shift and input delay
	// ------------------------------------------------------------
	localparam int SHIFT_W = 8;
	localparam int SHIFT_INV = 7;
	localparam logic [SHIFT_W-1:0] SHIFT_RST = 8'h00;
	localparam int SHIFT_STEP_PS = 25;
	localparam int CLK_PERIOD_PS = 10000;
	localparam int WCLK_TAPS = 4;
	localparam int DLY_W = 4;
	localparam int DLY_TAPS = 16;
	localparam logic [DLY_W-1:0] DLY_RST = 4'h0;
	localparam int DLL_W = 7;

	// ------------------------------------------------------------
	// output gearing phases
	// ------------------------------------------------------------
	typedef enum logic [1:0] {PH_POSA, PH_NEGA, PH_POSB, PH_NEGB} ioc_phase_t;

endpackage

// ### rtl/ioc_sync.sv
`timescale 1ns/1ps
module ioc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// ------------------------------------------------------------
	// two-stage synchroniser
	// ------------------------------------------------------------
	// first stage is read by the second stage only
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
